// ===== common/fmt_pkg.sv
// shared constants and types for the remote output formatter
package fmt_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   // ctrl fields
   localparam int SUFFIX_BIT = 0;
   localparam int NOCR_BIT   = 1;
   localparam int NOLF_BIT   = 2;
   localparam int CONT_BIT   = 3;
   localparam int MASK_LSB   = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // ---------------------------------------------------------------
   // characters and string sizes
   // ---------------------------------------------------------------
   localparam logic [7:0] CH_0 = 8'h30;
   localparam logic [7:0] CH_1 = 8'h31;
   localparam logic [7:0] CH_2 = 8'h32;
   localparam logic [7:0] CH_9 = 8'h39;
   localparam logic [7:0] CH_PLUS = 8'h2b;
   localparam logic [7:0] CH_MINUS = 8'h2d;
   localparam logic [7:0] CH_DOT = 8'h2e;
   localparam logic [7:0] CH_E = 8'h45;
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_LF = 8'h0a;
   localparam int NUM_LEN    = 11;
   localparam int SUFFIX_LEN = 5;
   localparam int STAT_LEN   = 4;
   localparam int MASKQ_LEN  = 2;
   localparam int STR_MAX    = 18;
   localparam int EXP_STEP   = 3;
   localparam logic [6:0] ERR_REAR = 7'd31;
   localparam logic [3:0] MASK_QUERY = 4'h1;
   // status queries whose reply starts with "1" or with "10"
   localparam logic [8:0] PREFIX1_SET  = 9'h0f0;
   localparam logic [8:0] PREFIX10_SET = 9'h100;
   localparam logic [7:0] FUNC_CUR_A = 8'h03;
   localparam logic [7:0] FUNC_CUR_B = 8'h04;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NONE   = 4'h0, OP_TERM = 4'h1, OP_STATUS = 4'h2, OP_TRIG = 4'h3,
      OP_ERR    = 4'h4, OP_SUFFIX = 4'h5, OP_TERMSET = 4'h6, OP_MASK = 4'h7,
      OP_FUNC   = 4'h8, OP_CLEAR = 4'h9, OP_CONT = 4'ha
   } cmd_op_t;

   typedef enum logic [1:0] {
      SRC_NONE = 2'b00, SRC_STATUS = 2'b01, SRC_ERROR = 2'b10, SRC_NUMERIC = 2'b11
   } src_t;

   typedef struct packed {
      logic       valid;
      cmd_op_t    op;
      logic [7:0] arg;
   } cmd_t;

   typedef struct packed {
      logic            neg;
      logic [5:0][3:0] digit;     // digit[0] is most significant
      logic [1:0]      point;     // digits ahead of the point minus one
      logic            exp_neg;
      logic [1:0]      exp_eng;   // exponent is exp_eng times three
      logic            overrange;
   } reading_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       eoi;
   } talk_byte_t;

endpackage

// ===== design/remote_output_formatter.sv
// output side of the remote command interpreter: formatting, buffer, serial poll
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
module remote_output_formatter
   import fmt_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // ahb-lite register slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // executed commands from the input parser
   input  wire cmd_t        cmd,
   input  wire reading_t    reading,
   input  wire logic [15:0] status_bcd,
   // front/rear selector pin
   input  wire logic        rear_pin,
   // talker side of the bus interface
   input  wire logic        talk_en,
   input  wire logic        tx_ready,
   output talk_byte_t       tx,
   // serial poll and service request
   output logic [7:0]       spoll_byte,
   output logic             srq
);

   // ---------------------------------------------------------------
   // registers and declarations
   // ---------------------------------------------------------------
   logic [31:0]     ctrl_q;
   logic            rear_s1_q, rear_q;
   logic            str_open_q;
   logic            stat_cand_q, num_cand_q;
   logic [7:0]      stat_q [STAT_LEN];
   logic            stat_short_q;
   reading_t        rd_q;
   logic            err_pend_q, err31_q;
   logic [6:0]      err_code_q;
   logic [7:0]      str_q [STR_MAX];
   logic [4:0]      len_q, idx_q;
   logic            buf_full_q;
   logic [7:0]      spoll_q;
   logic            wr_pend_q, rd_hit_q;
   logic [7:0]      addr_q;
   logic [7:0]      str_d [STR_MAX];
   logic [4:0]      len_d;
   src_t            src;
   logic            is_cmd, term_now, cont_load, load_now, last_take;
   logic            rear_err, rear_keep;
   logic [5:0]      mask;
   logic [7:0]      sfx [SUFFIX_LEN];

   assign mask   = ctrl_q[MASK_LSB +: 6];
   assign is_cmd = cmd.valid && (cmd.op != OP_NONE);
   assign term_now = cmd.valid && (cmd.op == OP_TERM);
   // continuous readings stand alone when no string is being executed
   assign cont_load = cmd.valid && (cmd.op == OP_TRIG) && ctrl_q[CONT_BIT] && !str_open_q;
   // current function asked for at the rear input, flagged in the same cycle
   assign rear_err  = rear_q && cmd.valid && (cmd.op == OP_FUNC)
                      && ((cmd.arg == FUNC_CUR_A) || (cmd.arg == FUNC_CUR_B));
   assign rear_keep = err31_q && rear_q && !(cmd.valid && cmd.op == OP_FUNC);

   // ---------------------------------------------------------------
   // selector pin synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rear_s1_q <= 1'b0;
         rear_q    <= 1'b0;
      end else begin
         rear_s1_q <= rear_pin;
         rear_q    <= rear_s1_q;
      end
   end

   // ---------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // ---------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_q <= 1'b0;
         rd_hit_q  <= 1'b0;
         addr_q    <= 8'h00;
      end else begin
         wr_pend_q <= hsel && hready && htrans[1] && hwrite;
         rd_hit_q  <= hsel && hready && htrans[1] && !hwrite;
         if (hsel && hready && htrans[1]) begin
            addr_q <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (hsel && hready && htrans[1] && !hwrite) begin
         unique case (haddr[7:0])
            CTRL_ADDR:   hrdata <= ctrl_q;
            STATUS_ADDR: hrdata <= {err31_q, err_pend_q, err_code_q, 7'h00,
                                    3'b000, buf_full_q, 4'h0, spoll_q};
            default:     hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // configuration: commands and software share the ctrl register
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_pend_q && addr_q == CTRL_ADDR) begin
         ctrl_q <= hwdata;
      end else if (cmd.valid) begin
         unique case (cmd.op)
            OP_SUFFIX:  ctrl_q[SUFFIX_BIT] <= cmd.arg[0];
            OP_TERMSET: ctrl_q[NOLF_BIT:NOCR_BIT] <= cmd.arg[1:0];
            OP_MASK:    ctrl_q[MASK_LSB +: 6] <= cmd.arg[5:0];
            OP_CONT:    ctrl_q[CONT_BIT] <= cmd.arg[0];
            OP_CLEAR:   ctrl_q <= CTRL_RESET;
            default:    ctrl_q <= ctrl_q;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // candidates gathered while a string executes
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         str_open_q   <= 1'b0;
         stat_cand_q  <= 1'b0;
         num_cand_q   <= 1'b0;
         stat_short_q <= 1'b0;
         rd_q         <= '0;
         for (int i = 0; i < STAT_LEN; i++) begin
            stat_q[i] <= CH_0;
         end
      end else if (term_now) begin
         str_open_q  <= 1'b0;
         stat_cand_q <= 1'b0;
         num_cand_q  <= 1'b0;
      end else if (is_cmd && !cont_load) begin
         str_open_q <= 1'b1;
         if (cmd.op == OP_TRIG) begin
            num_cand_q <= 1'b1;
            rd_q       <= reading;
         end
         if (cmd.op == OP_STATUS) begin
            // snapshot taken here, only a later status command can alter it
            stat_cand_q  <= 1'b1;
            stat_short_q <= (cmd.arg[3:0] == MASK_QUERY);
            for (int i = 0; i < STAT_LEN; i++) begin
               stat_q[i] <= CH_0 + {4'h0, status_bcd[15 - 4*i -: 4]};
            end
            if (cmd.arg[3:0] == MASK_QUERY) begin
               stat_q[0] <= CH_0 + {1'b0, 7'(mask / 6'd10)};
               stat_q[1] <= CH_0 + {1'b0, 7'(mask % 6'd10)};
            end else if (PREFIX10_SET[cmd.arg[3:0]]) begin
               stat_q[0] <= CH_1;
               stat_q[1] <= CH_0;
            end else if (PREFIX1_SET[cmd.arg[3:0]]) begin
               stat_q[0] <= CH_1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // pending error and latched rear-input error
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         err31_q <= 1'b0;
      end else if (!rear_q) begin
         err31_q <= 1'b0;
      end else if (cmd.valid && cmd.op == OP_FUNC) begin
         err31_q <= rear_err;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         err_pend_q <= 1'b0;
         err_code_q <= 7'd0;
      end else begin
         // delivery clears first, a new error in the same cycle wins
         if (load_now && src == SRC_ERROR && !err31_q) begin
            err_pend_q <= 1'b0;
         end
         if (cmd.valid && cmd.op == OP_ERR) begin
            err_pend_q <= 1'b1;
            err_code_q <= cmd.arg[6:0];
         end else if (rear_err || rear_keep) begin
            err_pend_q <= 1'b1;
            err_code_q <= ERR_REAR;
         end else if (err31_q) begin
            // latch released, error 31 no longer stands
            err_pend_q <= 1'b0;
         end
         if (cmd.valid && cmd.op == OP_CLEAR) begin
            err_pend_q <= err31_q;
         end
      end
   end

   // ---------------------------------------------------------------
   // output selection and string formatting
   // ---------------------------------------------------------------
   always_comb begin
      if (term_now && stat_cand_q) begin
         src = SRC_STATUS;
      end else if ((term_now || cont_load) && err_pend_q) begin
         src = SRC_ERROR;
      end else if ((term_now && num_cand_q) || cont_load) begin
         src = SRC_NUMERIC;
      end else begin
         src = SRC_NONE;
      end
   end
   // loads wait for the terminator or a standalone continuous reading
   assign load_now = (src != SRC_NONE);

   always_comb begin
      sfx[0] = 8'h20;
      sfx[1] = 8'h56;
      sfx[2] = 8'h44;
      sfx[3] = 8'h43;
      sfx[4] = 8'h20;
   end

   always_comb begin
      reading_t r;
      r = cont_load ? reading : rd_q;
      for (int i = 0; i < STR_MAX; i++) begin
         str_d[i] = 8'h00;
      end
      len_d = 5'd0;
      unique case (src)
         SRC_STATUS: begin
            for (int i = 0; i < STAT_LEN; i++) begin
               str_d[i] = stat_q[i];
            end
            len_d = stat_short_q ? 5'(MASKQ_LEN) : 5'(STAT_LEN);
         end
         SRC_ERROR: begin
            str_d[0] = CH_PLUS;
            str_d[1] = CH_1;
            str_d[2] = CH_DOT;
            str_d[3] = CH_0;
            str_d[4] = CH_0;
            str_d[5] = CH_0 + {1'b0, 7'(err_code_q / 7'd10)};
            str_d[6] = CH_0 + {1'b0, 7'(err_code_q % 7'd10)};
            str_d[7] = CH_E;
            str_d[8] = CH_PLUS;
            str_d[9] = CH_2;
            str_d[10] = CH_1;
            len_d = 5'(NUM_LEN);
         end
         SRC_NUMERIC: begin
            str_d[0] = r.neg ? CH_MINUS : CH_PLUS;
            for (int j = 0; j < 7; j++) begin
               if (r.overrange) begin
                  str_d[1 + j] = (j == 1) ? CH_DOT : CH_9;
               end else if (j == int'(r.point) + 1) begin
                  str_d[1 + j] = CH_DOT;
               end else begin
                  str_d[1 + j] = CH_0 + {4'h0, r.digit[(j <= int'(r.point)) ? j : j - 1]};
               end
            end
            str_d[8] = CH_E;
            str_d[9] = (r.exp_neg && !r.overrange) ? CH_MINUS : CH_PLUS;
            str_d[10] = r.overrange ? CH_9 : CH_0 + 8'(EXP_STEP * r.exp_eng);
            len_d = 5'(NUM_LEN);
            if (ctrl_q[SUFFIX_BIT]) begin
               for (int i = 0; i < SUFFIX_LEN; i++) begin
                  str_d[NUM_LEN + i] = sfx[i];
               end
               len_d = 5'(NUM_LEN + SUFFIX_LEN);
            end
         end
         default: len_d = 5'd0;
      endcase
      if (src != SRC_NONE && !ctrl_q[NOCR_BIT]) begin
         str_d[len_d] = CH_CR;
         len_d = len_d + 5'd1;
      end
      if (src != SRC_NONE && !ctrl_q[NOLF_BIT]) begin
         str_d[len_d] = CH_LF;
         len_d = len_d + 5'd1;
      end
   end

   // ---------------------------------------------------------------
   // output buffer and talker stream
   // ---------------------------------------------------------------
   assign tx.valid = talk_en && buf_full_q;
   assign tx.data  = str_q[idx_q];
   assign tx.eoi   = (idx_q == len_q - 5'd1);
   assign last_take = tx.valid && tx_ready && tx.eoi;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         buf_full_q <= 1'b0;
         len_q      <= 5'd1;
         idx_q      <= 5'd0;
         for (int i = 0; i < STR_MAX; i++) begin
            str_q[i] <= 8'h00;
         end
      end else if (load_now) begin
         buf_full_q <= 1'b1;
         len_q      <= len_d;
         idx_q      <= 5'd0;
         for (int i = 0; i < STR_MAX; i++) begin
            str_q[i] <= str_d[i];
         end
      end else if (term_now || last_take || (cmd.valid && cmd.op == OP_CLEAR)) begin
         buf_full_q <= 1'b0;
         idx_q      <= 5'd0;
      end else if (tx.valid && tx_ready) begin
         idx_q <= idx_q + 5'd1;
      end
   end

   // ---------------------------------------------------------------
   // serial poll register and service request
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         spoll_q <= 8'h00;
      end else if (load_now) begin
         spoll_q[0] <= (src == SRC_NUMERIC) && (cont_load ? reading.overrange
                                                          : rd_q.overrange);
         spoll_q[3:1] <= 3'b000;
         spoll_q[4] <= 1'b1;
         spoll_q[5] <= (src == SRC_ERROR);
         spoll_q[6] <= |(mask & {src == SRC_ERROR, 1'b1, 3'b000,
                        (src == SRC_NUMERIC) && (cont_load ? reading.overrange
                                                           : rd_q.overrange)});
         spoll_q[7] <= 1'b0;
      end else if (term_now || last_take || (cmd.valid && cmd.op == OP_CLEAR)) begin
         spoll_q <= 8'h00;
      end
   end

   assign spoll_byte = spoll_q;
   assign srq        = spoll_q[6];

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_term;
      cmd.valid && cmd.op == OP_TERM;
   endsequence

   a_load_sets_dav: assert property (load_now |=> spoll_q[4] && buf_full_q)
      else $error("load did not raise data available");
   a_talk_gated: assert property (!talk_en |-> !tx.valid)
      else $error("byte offered while not talker");
   a_num_length: assert property (load_now && src == SRC_NUMERIC && ctrl_q[NOCR_BIT]
      && ctrl_q[NOLF_BIT] |=> len_q == (ctrl_q[SUFFIX_BIT] ? 5'd16 : 5'd11))
      else $error("numeric length wrong");
   a_err_len: assert property (load_now && src == SRC_ERROR && !ctrl_q[NOCR_BIT]
      && !ctrl_q[NOLF_BIT] |=> len_q == 5'd13 && str_q[11] == CH_CR)
      else $error("error message length wrong");
   a_status_prio: assert property (s_term ##0 stat_cand_q |-> src == SRC_STATUS)
      else $error("status lost priority");
   a_keep_error: assert property (s_term ##0 stat_cand_q && err_pend_q |=> err_pend_q)
      else $error("status reply dropped pending error");
   a_read_empties: assert property (last_take && !load_now |=> !buf_full_q
      ##1 !tx.valid)
      else $error("buffer not emptied after read");
   a_poll_cleared: assert property (s_term ##0 !load_now |=> spoll_q == 8'h00)
      else $error("poll register not cleared on new string");
   a_rqs_mask: assert property (load_now |=> srq == |(mask & spoll_q[5:0]))
      else $error("request bit disagrees with mask");
   a_no_early_load: assert property (str_open_q && !term_now && !cont_load
      |-> !load_now)
      else $error("buffer loaded mid-string");
   a_exp_multiple: assert property (load_now && src == SRC_NUMERIC |=>
      (str_q[10] - CH_0) % 8'd3 == 8'h00)
      else $error("exponent not multiple of three");

endmodule

// ===== tb/ctrl_model.sv
// bus controller model: talker addressing and paced byte acceptance
`timescale 1ns/100ps
module ctrl_model
   import fmt_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // bench controls
   input  wire logic       listen,
   input  wire logic       slow,
   // talker handshake
   input  wire talk_byte_t tx,
   output logic            talk_en,
   output logic            tx_ready
);
   logic [7:0] rx_q[$];
   int         eoi_n;
   logic       pace_q;

   // no byte is accepted unless addressed as talker
   assign talk_en  = listen;
   assign tx_ready = listen && (!slow || pace_q);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pace_q <= 1'b0;
      end else begin
         pace_q <= ~pace_q;
      end
   end

   // collect bytes, remember where the end marker came
   always @(posedge clock) begin
      if (tx.valid && tx_ready) begin
         rx_q.push_back(tx.data);
         if (tx.eoi) begin
            eoi_n <= rx_q.size();
         end
      end
   end
endmodule

// ===== tb/remote_output_formatter_tb.sv
// self-checking bench for the remote output formatter
`timescale 1ns/100ps
module remote_output_formatter_tb
   import fmt_pkg::*;
;
   logic        clock, rst_n, hsel, hwrite, hready, hreadyout, hresp, rear_pin;
   logic        talk_en, tx_ready, srq, listen, slow;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] status_bcd;
   logic [7:0]  spoll_byte;
   cmd_t        cmd;
   reading_t    reading;
   talk_byte_t  tx;
   int          mismatches, n_compared;
   localparam string EOL = "\015\012";
   localparam string NUM = "+1.23456E-6";

   assign hready = hreadyout;
   remote_output_formatter dut (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hresp, .hrdata, .cmd, .reading, .status_bcd,
      .rear_pin, .talk_en, .tx_ready, .tx, .spoll_byte, .srq);
   ctrl_model ctl (.clock, .rst_n, .listen, .slow, .tx, .talk_en, .tx_ready);

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %0t %s got %h expected %h", $time, m, g, e);
      end
   endtask

   task automatic hang(input int n);
      if (n >= 100) begin
         mismatches++;
         $display("BAD %0t wait ran out", $time);
         stop_test();
      end
   endtask

   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      int n;
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'h2;
      n = 0;
      do begin @(posedge clock); n++; end while (hready !== 1'b1 && n < 100);
      hang(n);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      n = 0;
      do begin @(posedge clock); n++; end while (hready !== 1'b1 && n < 100);
      hang(n);
      rd = hrdata;
   endtask

   task automatic op(input cmd_op_t o, input logic [7:0] a);
      cmd <= '{1'b1, o, a};
      @(posedge clock);
   endtask

   task automatic term;
      op(OP_TERM, 8'h00);
      cmd <= '0;
      @(posedge clock);
   endtask

   task automatic trig(input logic ng, input logic ov);
      reading <= '{ng, 24'h654321, 2'd0, 1'b1, 2'd2, ov};
      op(OP_TRIG, 8'h00);
   endtask

   task automatic take(input string s, input logic sl);
      int n;
      ctl.rx_q.delete();
      ctl.eoi_n = 0;
      slow <= sl;
      listen <= 1'b1;
      n = 0;
      while (ctl.eoi_n == 0 && n < 100) begin @(posedge clock); n++; end
      hang(n);
      listen <= 1'b0;
      @(posedge clock);
      chk(ctl.rx_q.size(), s.len(), "byte count");
      chk(ctl.eoi_n, s.len(), "end marker place");
      for (int i = 0; i < s.len(); i++) chk(ctl.rx_q[i], s[i], "byte");
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      bus(1'b0, CTRL_ADDR, 32'h0);
      chk(rd, CTRL_RESET, "ctrl reset");
      bus(1'b0, STATUS_ADDR, 32'h0);
      chk(rd, 32'h0, "status reset");
      chk(hresp, 1'b0, "response okay");
      bus(1'b1, 32'h40, 32'hffff_ffff);
      bus(1'b0, 32'h40, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      bus(1'b0, CTRL_ADDR, 32'h0);
      chk(rd, CTRL_RESET, "ctrl after unmapped write");
   endtask

   task automatic t_num;
      op(OP_FUNC, 8'h01);
      term;
      chk(spoll_byte, 8'h00, "load without output command");
      trig(1'b0, 1'b0);
      op(OP_FUNC, 8'h01);
      chk(spoll_byte, 8'h00, "load before string end");
      term;
      chk(spoll_byte, 8'h10, "data available");
      bus(1'b0, STATUS_ADDR, 32'h0);
      chk(rd, 32'h0000_1010, "status word");
      repeat (3) @(posedge clock);
      chk(tx.valid, 1'b0, "talked unaddressed");
      take({NUM, EOL}, 1'b1);
      chk(spoll_byte, 8'h00, "poll after read");
      ctl.rx_q.delete();
      listen <= 1'b1;
      repeat (6) @(posedge clock);
      listen <= 1'b0;
      chk(ctl.rx_q.size(), 0, "second read");
   endtask

   task automatic t_fmt;
      bus(1'b1, CTRL_ADDR, 32'h1);
      trig(1'b1, 1'b1);
      term;
      chk(spoll_byte, 8'h11, "overrange poll");
      take({"-9.99999E+9 VDC ", EOL}, 1'b0);
      op(OP_ERR, 8'd71);
      term;
      chk(spoll_byte, 8'h30, "error poll");
      take({"+1.0071E+21", EOL}, 1'b0);
      status_bcd <= 16'h1234;
      op(OP_STATUS, 8'h00);
      status_bcd <= 16'h9876;
      term;
      take({"1234", EOL}, 1'b0);
      bus(1'b1, CTRL_ADDR, 32'h0);
   endtask

   task automatic t_prio;
      trig(1'b0, 1'b0);
      op(OP_ERR, 8'd42);
      status_bcd <= 16'h5678;
      op(OP_STATUS, 8'h00);
      term;
      take({"5678", EOL}, 1'b0);
      trig(1'b0, 1'b0);
      term;
      take({"+1.0042E+21", EOL}, 1'b0);
      trig(1'b0, 1'b0);
      term;
      take({NUM, EOL}, 1'b0);
      trig(1'b0, 1'b0);
      op(OP_ERR, 8'd42);
      term;
      take({"+1.0042E+21", EOL}, 1'b1);
   endtask

   task automatic t_term;
      op(OP_TERMSET, 8'h03);
      op(OP_TERMSET, 8'h01);
      trig(1'b0, 1'b0);
      op(OP_FUNC, 8'h01);
      term;
      take({NUM, "\012"}, 1'b1);
      op(OP_TERMSET, 8'h03);
      trig(1'b0, 1'b0);
      term;
      take(NUM, 1'b0);
      op(OP_TERMSET, 8'h00);
      term;
   endtask

   task automatic t_cont;
      op(OP_CONT, 8'h01);
      op(OP_MASK, 8'h10);
      op(OP_SUFFIX, 8'h01);
      term;
      trig(1'b0, 1'b0);
      cmd <= '0;
      @(posedge clock);
      chk(spoll_byte, 8'h50, "continuous load");
      take({NUM, " VDC ", EOL}, 1'b0);
      op(OP_CLEAR, 8'h00);
      term;
      bus(1'b0, CTRL_ADDR, 32'h0);
      chk(rd, CTRL_RESET, "ctrl after clear");
   endtask

   task automatic t_srq;
      bus(1'b1, CTRL_ADDR, 32'h2000);
      op(OP_ERR, 8'd71);
      term;
      chk(spoll_byte, 8'h70, "masked error poll");
      chk(srq, 1'b1, "service request");
      take({"+1.0071E+21", EOL}, 1'b0);
      op(OP_STATUS, {4'h0, MASK_QUERY});
      term;
      chk(spoll_byte, 8'h10, "unmasked poll");
      chk(srq, 1'b0, "no service request");
      take({"32", EOL}, 1'b0);
      bus(1'b1, CTRL_ADDR, 32'h0100);
      trig(1'b0, 1'b1);
      term;
      chk(spoll_byte, 8'h51, "overrange request");
      term;
      chk(spoll_byte, 8'h00, "poll after new string");
      chk(srq, 1'b0, "request after new string");
      bus(1'b1, CTRL_ADDR, 32'h0);
   endtask

   task automatic t_rear;
      rear_pin <= 1'b1;
      repeat (3) @(posedge clock);
      op(OP_FUNC, FUNC_CUR_A);
      term;
      take({"+1.0031E+21", EOL}, 1'b0);
      bus(1'b0, STATUS_ADDR, 32'h0);
      chk(rd, 32'hcf80_0000, "rear error latched");
      trig(1'b0, 1'b0);
      term;
      take({"+1.0031E+21", EOL}, 1'b1);
      rear_pin <= 1'b0;
      repeat (4) @(posedge clock);
      trig(1'b0, 1'b0);
      term;
      take({NUM, EOL}, 1'b0);
   endtask

   initial begin
      rst_n = 1'b0;
      {hsel, hwrite, rear_pin, listen, slow} = '0;
      {haddr, hwdata, rd, htrans, hsize, status_bcd} = '0;
      cmd = '0;
      reading = '0;
      mismatches = 0;
      n_compared = 0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      t_regs;
      t_num;
      t_fmt;
      t_prio;
      t_term;
      t_srq;
      t_cont;
      t_rear;
      stop_test;
   end
endmodule
